// file: rtl/mcu8_dec_pkg.sv
// Package of constants and types for the opcode decoder
package mcu8_dec_pkg;
	// ==========================================
	// Operations
	typedef enum logic [4:0] {
		OP_NONE, OP_BRANCH_NOT_EQUAL, OP_BRANCH_EQUAL, OP_BRANCH_CARRY_CLEAR, OP_BRANCH_CARRY_SET,
		OP_CALL_SUBROUTINE, OP_JUMP_FAR, OP_MOVE_IMMEDIATE, OP_RETURN_INTERRUPT, OP_RETURN_SUBROUTINE,
		OP_COMPLEMENT_ACC, OP_ROTATE_ACC_LEFT, OP_INCREMENT_MEM, OP_DECREMENT_MEM,
		OP_LOAD_ACCUMULATOR, OP_STORE_ACCUMULATOR, OP_ADD, OP_SUBTRACT, OP_COMPARE_WITH_MEM, OP_AND,
		OP_TEST_CLEAR_BRANCH, OP_TEST_SET_BRANCH, OP_CLEAR_BIT, OP_SET_BIT
	} mcu8_op_t;
	// ==========================================
	// Addressing modes
	typedef enum logic [3:0] {
		AM_INHERENT, AM_IMMEDIATE, AM_DIRECT, AM_SHORT_DIRECT, AM_EXTENDED,
		AM_RELATIVE, AM_BIT_SET_CLEAR, AM_BIT_TEST_BRANCH, AM_REG_INDIRECT
	} mcu8_mode_t;
	// ==========================================
	// Data-space locations
	localparam logic [7:0] ADDR_X_PTR = 8'h80;
	localparam logic [7:0] ADDR_Y_PTR = 8'h81;
	localparam logic [7:0] ADDR_SHORT_BASE = 8'h80;
	localparam logic [7:0] ADDR_ACC = 8'hFF;
	// ==========================================
	// Opcode fields
	localparam int PTR_SEL_BIT = 4;
	localparam int REL_MSB = 4;
	localparam int BIT_SENSE_POS = 3;
	// ==========================================
	// Lengths and cycle counts
	localparam logic [1:0] LEN_ONE = 2'h1;
	localparam logic [1:0] LEN_TWO = 2'h2;
	localparam logic [1:0] LEN_THREE = 2'h3;
	localparam logic [2:0] CYC_BRANCH = 3'h2;
	localparam logic [2:0] CYC_RETURN = 3'h2;
	localparam logic [2:0] CYC_STD = 3'h4;
	localparam logic [2:0] CYC_BIT_TEST = 3'h5;
	localparam logic [2:0] CYC_NOP = 3'h2;
	localparam int PC_W = 12;
endpackage

// file: rtl/mcu8_dec_table.sv
// Combinational opcode classification table
`timescale 1ns/1ps
`default_nettype none
module mcu8_dec_table (
	// Opcode in
	input wire logic [7:0] opcode,
	// Classification out
	output mcu8_dec_pkg::mcu8_op_t op,
	output mcu8_dec_pkg::mcu8_mode_t mode,
	output logic [1:0] length,
	output logic [2:0] cycles,
	output logic reserved
);
	// ==========================================
	// Decode
	always_comb begin
		op = mcu8_dec_pkg::OP_NONE;
		mode = mcu8_dec_pkg::AM_INHERENT;
		length = mcu8_dec_pkg::LEN_ONE;
		cycles = mcu8_dec_pkg::CYC_NOP;
		reserved = 1'b0;
		case (opcode[7:4])
			4'h0, 4'h1: begin
				op = mcu8_dec_pkg::OP_BRANCH_NOT_EQUAL;
				mode = mcu8_dec_pkg::AM_RELATIVE;
				cycles = mcu8_dec_pkg::CYC_BRANCH;
			end
			4'h2, 4'h3: begin
				op = mcu8_dec_pkg::OP_BRANCH_EQUAL;
				mode = mcu8_dec_pkg::AM_RELATIVE;
				cycles = mcu8_dec_pkg::CYC_BRANCH;
			end
			4'h4, 4'h5: begin
				op = mcu8_dec_pkg::OP_BRANCH_CARRY_CLEAR;
				mode = mcu8_dec_pkg::AM_RELATIVE;
				cycles = mcu8_dec_pkg::CYC_BRANCH;
			end
			4'h6, 4'h7: begin
				op = mcu8_dec_pkg::OP_BRANCH_CARRY_SET;
				mode = mcu8_dec_pkg::AM_RELATIVE;
				cycles = mcu8_dec_pkg::CYC_BRANCH;
			end
			4'h8, 4'h9: begin
				op = opcode[4] ? mcu8_dec_pkg::OP_JUMP_FAR : mcu8_dec_pkg::OP_CALL_SUBROUTINE;
				mode = mcu8_dec_pkg::AM_EXTENDED;
				length = mcu8_dec_pkg::LEN_TWO;
				cycles = mcu8_dec_pkg::CYC_STD;
			end
			4'hA: begin
				if (opcode[3]) begin
					op = opcode[2] ? mcu8_dec_pkg::OP_LOAD_ACCUMULATOR : mcu8_dec_pkg::OP_INCREMENT_MEM;
					mode = mcu8_dec_pkg::AM_SHORT_DIRECT;
					cycles = mcu8_dec_pkg::CYC_STD;
				end else begin
					reserved = 1'b1;
				end
			end
			4'hB: begin
				cycles = mcu8_dec_pkg::CYC_STD;
				if (opcode[3]) begin
					op = opcode[2] ? mcu8_dec_pkg::OP_STORE_ACCUMULATOR : mcu8_dec_pkg::OP_DECREMENT_MEM;
					mode = mcu8_dec_pkg::AM_SHORT_DIRECT;
				end else begin
					case (opcode[2:0])
						3'h0: begin
							op = mcu8_dec_pkg::OP_MOVE_IMMEDIATE;
							mode = mcu8_dec_pkg::AM_IMMEDIATE;
							length = mcu8_dec_pkg::LEN_THREE;
						end
						3'h2: begin
							op = mcu8_dec_pkg::OP_RETURN_INTERRUPT;
							cycles = mcu8_dec_pkg::CYC_RETURN;
						end
						3'h3: begin
							op = mcu8_dec_pkg::OP_RETURN_SUBROUTINE;
							cycles = mcu8_dec_pkg::CYC_RETURN;
						end
						3'h4: op = mcu8_dec_pkg::OP_COMPLEMENT_ACC;
						3'h5: op = mcu8_dec_pkg::OP_ROTATE_ACC_LEFT;
						default: begin
							reserved = 1'b1;
							cycles = mcu8_dec_pkg::CYC_NOP;
						end
					endcase
				end
			end
			4'hC: begin
				op = opcode[mcu8_dec_pkg::BIT_SENSE_POS] ? mcu8_dec_pkg::OP_TEST_SET_BRANCH
					: mcu8_dec_pkg::OP_TEST_CLEAR_BRANCH;
				mode = mcu8_dec_pkg::AM_BIT_TEST_BRANCH;
				length = mcu8_dec_pkg::LEN_THREE;
				cycles = mcu8_dec_pkg::CYC_BIT_TEST;
			end
			4'hD: begin
				op = opcode[mcu8_dec_pkg::BIT_SENSE_POS] ? mcu8_dec_pkg::OP_SET_BIT
					: mcu8_dec_pkg::OP_CLEAR_BIT;
				mode = mcu8_dec_pkg::AM_BIT_SET_CLEAR;
				length = mcu8_dec_pkg::LEN_TWO;
				cycles = mcu8_dec_pkg::CYC_STD;
			end
			default: begin
				// Rows E and F: opcode map is authoritative
				cycles = mcu8_dec_pkg::CYC_STD;
				case (opcode[2:0])
					3'h0: op = mcu8_dec_pkg::OP_LOAD_ACCUMULATOR;
					3'h1: op = mcu8_dec_pkg::OP_STORE_ACCUMULATOR;
					3'h2: op = mcu8_dec_pkg::OP_ADD;
					3'h3: op = mcu8_dec_pkg::OP_SUBTRACT;
					3'h4: op = mcu8_dec_pkg::OP_COMPARE_WITH_MEM;
					3'h5: op = mcu8_dec_pkg::OP_AND;
					3'h6: op = mcu8_dec_pkg::OP_INCREMENT_MEM;
					default: op = mcu8_dec_pkg::OP_DECREMENT_MEM;
				endcase
				if (!opcode[3]) begin
					mode = mcu8_dec_pkg::AM_REG_INDIRECT;
				end else begin
					length = mcu8_dec_pkg::LEN_TWO;
					mode = opcode[4] ? mcu8_dec_pkg::AM_DIRECT : mcu8_dec_pkg::AM_IMMEDIATE;
					if (!opcode[4] && (opcode[2:0] == 3'h1 || opcode[2:0] == 3'h6 || opcode[2:0] == 3'h7)) begin
						op = mcu8_dec_pkg::OP_NONE;
						mode = mcu8_dec_pkg::AM_INHERENT;
						length = mcu8_dec_pkg::LEN_ONE;
						cycles = mcu8_dec_pkg::CYC_NOP;
						reserved = 1'b1;
					end
				end
			end
		endcase
	end
endmodule
`default_nettype wire

// file: rtl/mcu8_opcode_decoder.sv
// Registered opcode decoder with target, address and flag helpers
`timescale 1ns/1ps
`default_nettype none
module mcu8_opcode_decoder (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic srst,
	// Fetch side
	input wire logic op_valid,
	input wire logic [7:0] opcode,
	input wire logic [7:0] operand1,
	input wire logic [7:0] operand2,
	input wire logic [11:0] pc,
	// Execution state
	input wire logic flag_zero,
	input wire logic flag_carry,
	input wire logic [7:0] x_value,
	input wire logic [7:0] y_value,
	input wire logic [7:0] mem_data,
	input wire logic [7:0] cmp_reg,
	// Decoded outputs
	output logic dec_valid,
	output mcu8_dec_pkg::mcu8_op_t dec_op,
	output mcu8_dec_pkg::mcu8_mode_t dec_mode,
	output logic [1:0] dec_length,
	output logic [2:0] dec_cycles,
	output logic dec_reserved,
	output logic [7:0] dec_ea,
	output logic dec_rmw,
	output logic [2:0] dec_bit,
	output logic [7:0] dec_imm,
	output logic dec_taken,
	output logic [11:0] dec_next_pc,
	output logic dec_carry_we,
	output logic dec_carry
);
	// ==========================================
	// Classification
	mcu8_dec_pkg::mcu8_op_t t_op;
	mcu8_dec_pkg::mcu8_mode_t t_mode;
	logic [1:0] t_len;
	logic [2:0] t_cyc;
	logic t_res;

	mcu8_dec_table u_table (
		.opcode(opcode),
		.op(t_op),
		.mode(t_mode),
		.length(t_len),
		.cycles(t_cyc),
		.reserved(t_res)
	);

	function automatic logic [11:0] rel_target(input logic [11:0] base, input logic [7:0] off, input logic wide);
		logic [11:0] ext;
		ext = wide ? {{4{off[7]}}, off} : {{7{off[mcu8_dec_pkg::REL_MSB]}}, off[4:0]};
		return 12'(base + ext);
	endfunction

	// ==========================================
	// Next-value logic
	logic next_valid, next_reserved, next_rmw, next_taken, next_carry_we, next_carry;
	mcu8_dec_pkg::mcu8_op_t next_op;
	mcu8_dec_pkg::mcu8_mode_t next_mode;
	logic [1:0] next_length;
	logic [2:0] next_cycles, next_bit;
	logic [7:0] next_ea, next_imm;
	logic [11:0] next_pc_val, seq_pc;
	logic tested;

	always_comb begin
		seq_pc = 12'(pc + {10'h000, t_len});
		tested = mem_data[opcode[2:0]];
		next_valid = op_valid;
		next_op = t_op;
		next_mode = t_mode;
		next_length = t_len;
		next_cycles = t_cyc;
		next_reserved = t_res;
		next_bit = opcode[2:0];
		next_imm = 8'h00;
		next_ea = 8'h00;
		next_rmw = 1'b0;
		next_taken = 1'b0;
		next_carry_we = 1'b0;
		next_carry = 1'b0;
		next_pc_val = seq_pc;
		case (t_mode)
			mcu8_dec_pkg::AM_SHORT_DIRECT: next_ea = 8'(mcu8_dec_pkg::ADDR_SHORT_BASE + {6'h00, opcode[1:0]});
			mcu8_dec_pkg::AM_REG_INDIRECT: next_ea = opcode[mcu8_dec_pkg::PTR_SEL_BIT] ? y_value : x_value;
			mcu8_dec_pkg::AM_DIRECT, mcu8_dec_pkg::AM_BIT_SET_CLEAR, mcu8_dec_pkg::AM_BIT_TEST_BRANCH: next_ea = operand1;
			mcu8_dec_pkg::AM_IMMEDIATE: begin
				next_imm = (t_op == mcu8_dec_pkg::OP_MOVE_IMMEDIATE) ? operand2 : operand1;
				next_ea = (t_op == mcu8_dec_pkg::OP_MOVE_IMMEDIATE) ? operand1 : 8'h00;
			end
			default: next_ea = 8'h00;
		endcase
		case (t_op)
			mcu8_dec_pkg::OP_BRANCH_NOT_EQUAL: next_taken = !flag_zero;
			mcu8_dec_pkg::OP_BRANCH_EQUAL: next_taken = flag_zero;
			mcu8_dec_pkg::OP_BRANCH_CARRY_CLEAR: next_taken = !flag_carry;
			mcu8_dec_pkg::OP_BRANCH_CARRY_SET: next_taken = flag_carry;
			mcu8_dec_pkg::OP_TEST_SET_BRANCH, mcu8_dec_pkg::OP_TEST_CLEAR_BRANCH: begin
				next_taken = (t_op == mcu8_dec_pkg::OP_TEST_SET_BRANCH) ? tested : !tested;
				next_carry_we = 1'b1;
				next_carry = tested;
				next_rmw = 1'b1;
			end
			mcu8_dec_pkg::OP_COMPARE_WITH_MEM: begin
				next_carry_we = 1'b1;
				next_carry = cmp_reg < mem_data;
			end
			mcu8_dec_pkg::OP_INCREMENT_MEM, mcu8_dec_pkg::OP_DECREMENT_MEM,
			mcu8_dec_pkg::OP_SET_BIT, mcu8_dec_pkg::OP_CLEAR_BIT: next_rmw = 1'b1;
			mcu8_dec_pkg::OP_CALL_SUBROUTINE, mcu8_dec_pkg::OP_JUMP_FAR: begin
				next_taken = 1'b1;
				next_pc_val = {opcode[3:0], operand1};
			end
			default: next_taken = 1'b0;
		endcase
		if (next_taken && t_mode == mcu8_dec_pkg::AM_RELATIVE) begin
			next_pc_val = rel_target(seq_pc, opcode, 1'b0);
		end else if (next_taken && t_mode == mcu8_dec_pkg::AM_BIT_TEST_BRANCH) begin
			next_pc_val = rel_target(seq_pc, operand2, 1'b1);
		end
		if (!op_valid) begin
			next_op = mcu8_dec_pkg::OP_NONE;
			next_rmw = 1'b0;
			next_taken = 1'b0;
			next_carry_we = 1'b0;
		end
	end

	// ==========================================
	// Registers
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			dec_valid <= 1'b0;
			dec_op <= mcu8_dec_pkg::OP_NONE;
			dec_mode <= mcu8_dec_pkg::AM_INHERENT;
			dec_length <= mcu8_dec_pkg::LEN_ONE;
			dec_cycles <= mcu8_dec_pkg::CYC_NOP;
			dec_reserved <= 1'b0;
			dec_ea <= 8'h00;
			dec_rmw <= 1'b0;
			dec_bit <= 3'h0;
			dec_imm <= 8'h00;
			dec_taken <= 1'b0;
			dec_next_pc <= 12'h000;
			dec_carry_we <= 1'b0;
			dec_carry <= 1'b0;
		end else begin
			dec_valid <= next_valid;
			dec_op <= next_op;
			dec_mode <= next_mode;
			dec_length <= next_length;
			dec_cycles <= next_cycles;
			dec_reserved <= next_reserved;
			dec_ea <= next_ea;
			dec_rmw <= next_rmw;
			dec_bit <= next_bit;
			dec_imm <= next_imm;
			dec_taken <= next_taken;
			dec_next_pc <= next_pc_val;
			dec_carry_we <= next_carry_we;
			dec_carry <= next_carry;
		end
	end

	// ==========================================
	// Checks
	sequence s_fetch_short_branch;
		op_valid && opcode[7] == 1'b0;
	endsequence
	chk_branch_timing: assert property (@(posedge ref_clk) disable iff (srst)
		s_fetch_short_branch |=> dec_cycles == 3'h2 && dec_length == 2'h1 && dec_mode == mcu8_dec_pkg::AM_RELATIVE)
		else $error("short branch length or cycles wrong");
	chk_carry_branch_sense: assert property (@(posedge ref_clk) disable iff (srst)
		op_valid && opcode[7:5] == 3'b010 |=> dec_taken == !$past(flag_carry))
		else $error("carry clear branch sense wrong");
	chk_rel_target: assert property (@(posedge ref_clk) disable iff (srst)
		op_valid && opcode[7:5] == 3'b001 && flag_zero |=>
		dec_next_pc == 12'($past(pc) + 12'h001 + {{7{$past(opcode[4])}}, $past(opcode[4:0])}))
		else $error("relative target wrong");
	chk_bit_test_info: assert property (@(posedge ref_clk) disable iff (srst)
		op_valid && opcode[7:4] == 4'hC |=> dec_cycles == 3'h5 && dec_length == 2'h3 && dec_carry_we)
		else $error("bit test decode wrong");
	chk_bit_test_carry: assert property (@(posedge ref_clk) disable iff (srst)
		op_valid && opcode[7:4] == 4'hC |=> dec_carry == $past(mem_data[opcode[2:0]]))
		else $error("tested bit not copied to carry");
	chk_far_target: assert property (@(posedge ref_clk) disable iff (srst)
		op_valid && opcode[7:5] == 3'b100 |=> dec_next_pc == {$past(opcode[3:0]), $past(operand1)} && dec_cycles == 3'h4)
		else $error("far target wrong");
	chk_short_direct_ea: assert property (@(posedge ref_clk) disable iff (srst)
		op_valid && opcode[7:5] == 3'b101 && opcode[3] |=> dec_ea == {6'b100000, $past(opcode[1:0])} && dec_length == 2'h1)
		else $error("short direct address wrong");
	chk_ptr_select: assert property (@(posedge ref_clk) disable iff (srst)
		op_valid && opcode[7:5] == 3'b111 && !opcode[3] |=> dec_ea == ($past(opcode[4]) ? $past(y_value) : $past(x_value)))
		else $error("pointer select wrong");
	chk_compare_carry: assert property (@(posedge ref_clk) disable iff (srst)
		op_valid && opcode == 8'hE4 |=> dec_carry == ($past(cmp_reg) < $past(mem_data)))
		else $error("compare carry wrong");
	chk_rmw_mark: assert property (@(posedge ref_clk) disable iff (srst)
		op_valid && opcode[7:4] == 4'hD |=> dec_rmw && dec_cycles == 3'h4 && dec_length == 2'h2)
		else $error("bit set or clear not read-modify-write");
	chk_reserved_safe: assert property (@(posedge ref_clk) disable iff (srst)
		dec_reserved |-> !dec_rmw && !dec_taken && dec_op == mcu8_dec_pkg::OP_NONE)
		else $error("reserved opcode has effect");
	chk_idle_no_effect: assert property (@(posedge ref_clk) disable iff (srst)
		!op_valid |=> !dec_valid && dec_op == mcu8_dec_pkg::OP_NONE && !dec_taken && !dec_rmw && !dec_carry_we)
		else $error("idle slot has effect");
	chk_move_fields: assert property (@(posedge ref_clk) disable iff (srst)
		op_valid && opcode == 8'hB0 |=> dec_length == 2'h3 && dec_ea == $past(operand1) && dec_imm == $past(operand2))
		else $error("move immediate fields wrong");
	chk_return_cycles: assert property (@(posedge ref_clk) disable iff (srst)
		op_valid && opcode[7:1] == 7'b1011001 |=> dec_cycles == 3'h2 && dec_length == 2'h1)
		else $error("return timing wrong");
	chk_indirect_rmw: assert property (@(posedge ref_clk) disable iff (srst)
		op_valid && opcode[7:5] == 3'b111 && opcode[3:1] == 3'b011 |=> dec_rmw && dec_cycles == 3'h4 && dec_length == 2'h1)
		else $error("indirect increment or decrement wrong");
endmodule
`default_nettype wire

// file: verif/mcu8_fetch_model.sv
// Data-space model giving the byte at operand1, pointers and accumulator
`timescale 1ns/1ps
`default_nettype none
module mcu8_fetch_model (
	// Address byte from fetch
	input wire logic [7:0] operand1,
	// Data-space reads
	output logic [7:0] mem_data,
	output logic [7:0] x_value,
	output logic [7:0] y_value,
	output logic [7:0] cmp_reg
);
	logic [7:0] ram [256];
	integer mseed;
	initial begin
		mseed = 32'h51C3;
		for (int i = 0; i < 256; i++) begin
			ram[i] = 8'($random(mseed));
		end
	end
	assign mem_data = ram[operand1];
	assign x_value = ram[8'h80];
	assign y_value = ram[8'h81];
	assign cmp_reg = ram[8'hFF];
endmodule
`default_nettype wire

// file: verif/mcu8_opcode_decoder_bench.sv
// Self-checking bench for the opcode decoder
`timescale 1ns/1ps
`default_nettype none
module mcu8_opcode_decoder_bench;
	typedef struct packed {
		mcu8_dec_pkg::mcu8_op_t op;
		logic [1:0] len;
		logic [2:0] cyc;
		logic [2:0] bn;
		logic v, res, rmw, tkk, tk, brk, eak, cv;
		logic [1:0] cc;
		logic [11:0] npc;
		logic [7:0] ea;
		mcu8_dec_pkg::mcu8_mode_t mode;
		logic [7:0] imm;
		int stamp;
	} mcu8_note_t;
	logic ref_clk, srst, op_valid, flag_zero, flag_carry;
	logic [7:0] opcode, operand1, operand2, x_value, y_value, mem_data, cmp_reg;
	logic [11:0] pc, dec_next_pc;
	logic dec_valid, dec_reserved, dec_rmw, dec_taken, dec_carry_we, dec_carry;
	mcu8_dec_pkg::mcu8_op_t dec_op;
	mcu8_dec_pkg::mcu8_mode_t dec_mode;
	logic [1:0] dec_length;
	logic [2:0] dec_cycles, dec_bit;
	logic [7:0] dec_ea, dec_imm;
	integer seed = 32'he76d;
	int mismatches = 0;
	int num_checks = 0;
	int cyc = 0;
	mcu8_note_t notes[$];
	mcu8_opcode_decoder dut (.ref_clk, .srst, .op_valid, .opcode, .operand1, .operand2, .pc, .flag_zero,
		.flag_carry, .x_value, .y_value, .mem_data, .cmp_reg, .dec_valid, .dec_op, .dec_mode, .dec_length,
		.dec_cycles, .dec_reserved, .dec_ea, .dec_rmw, .dec_bit, .dec_imm, .dec_taken, .dec_next_pc,
		.dec_carry_we, .dec_carry);
	mcu8_fetch_model fm (.operand1, .mem_data, .x_value, .y_value, .cmp_reg);
	// ==========================================
	// Clock and checking
	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) cyc <= cyc + 1;
	task automatic cmp_val(input string nm, input logic [11:0] e, input logic [11:0] g);
		num_checks++;
		if (g !== e) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic cmp_op(input mcu8_dec_pkg::mcu8_op_t e, input mcu8_dec_pkg::mcu8_op_t g);
		num_checks++;
		if (g !== e) begin
			mismatches++;
			$display("CHECK FAILED dec_op expected %0d seen %0d", e, g);
		end
	endtask
	task automatic check(input mcu8_note_t n);
		cmp_op(n.op, dec_op);
		cmp_val("dec_valid", 12'(n.v), 12'(dec_valid));
		cmp_val("dec_length", 12'(n.len), 12'(dec_length));
		cmp_val("dec_cycles", 12'(n.cyc), 12'(dec_cycles));
		cmp_val("dec_reserved", 12'(n.res), 12'(dec_reserved));
		cmp_val("dec_rmw", 12'(n.rmw), 12'(dec_rmw));
		cmp_val("dec_bit", 12'(n.bn), 12'(dec_bit));
		cmp_val("dec_mode", 12'(n.mode), 12'(dec_mode));
		cmp_val("dec_imm", 12'(n.imm), 12'(dec_imm));
		if (n.tkk) cmp_val("dec_taken", 12'(n.tk), 12'(dec_taken));
		if (n.brk) cmp_val("dec_next_pc", n.npc, dec_next_pc);
		if (n.eak) cmp_val("dec_ea", 12'(n.ea), 12'(dec_ea));
		if (n.cc != 2'h2) cmp_val("dec_carry_we", 12'(n.cc), 12'(dec_carry_we));
		if (n.cc == 2'h1) cmp_val("dec_carry", 12'(n.cv), 12'(dec_carry));
	endtask
	always @(posedge ref_clk) begin
		#2;
		if (notes.size() > 0 && notes[0].stamp < cyc) check(notes.pop_front());
	end
	// ==========================================
	// Expected decode
	function automatic mcu8_note_t predict(input logic v, input logic [7:0] oc, o1, o2, input logic [11:0] p,
			input logic z, cy, input logic [7:0] x, y, md, cr);
		mcu8_note_t n;
		mcu8_dec_pkg::mcu8_op_t alu [8];
		mcu8_dec_pkg::mcu8_op_t br [4];
		alu = '{mcu8_dec_pkg::OP_LOAD_ACCUMULATOR, mcu8_dec_pkg::OP_STORE_ACCUMULATOR, mcu8_dec_pkg::OP_ADD,
			mcu8_dec_pkg::OP_SUBTRACT, mcu8_dec_pkg::OP_COMPARE_WITH_MEM, mcu8_dec_pkg::OP_AND,
			mcu8_dec_pkg::OP_INCREMENT_MEM, mcu8_dec_pkg::OP_DECREMENT_MEM};
		br = '{mcu8_dec_pkg::OP_BRANCH_NOT_EQUAL, mcu8_dec_pkg::OP_BRANCH_EQUAL,
			mcu8_dec_pkg::OP_BRANCH_CARRY_CLEAR, mcu8_dec_pkg::OP_BRANCH_CARRY_SET};
		n = '0;
		n.op = mcu8_dec_pkg::OP_NONE;
		n.v = v;
		n.bn = oc[2:0];
		n.len = 2'h1;
		n.cyc = 3'h4;
		n.tkk = 1'b1;
		casez (oc)
			8'b0???????: begin
				n.op = br[oc[6:5]];
				n.cyc = 3'h2;
				n.mode = mcu8_dec_pkg::AM_RELATIVE;
				n.tk = (oc[6] ? cy : z) ^ ~oc[5];
				n.brk = 1'b1;
				n.npc = p + 12'h1 + (n.tk ? {{7{oc[4]}}, oc[4:0]} : 12'h0);
			end
			8'b100?????: begin
				n.op = oc[4] ? mcu8_dec_pkg::OP_JUMP_FAR : mcu8_dec_pkg::OP_CALL_SUBROUTINE;
				n.len = 2'h2;
				n.tk = 1'b1;
				n.brk = 1'b1;
				n.npc = {oc[3:0], o1};
				n.mode = mcu8_dec_pkg::AM_EXTENDED;
			end
			8'b101?1???: begin
				n.mode = mcu8_dec_pkg::AM_SHORT_DIRECT;
				n.op = oc[2] ? alu[{2'h0, oc[4]}] : alu[{2'h3, oc[4]}];
				n.rmw = ~oc[2];
				n.eak = 1'b1;
				n.ea = {6'h20, oc[1:0]};
			end
			8'hB0: begin
				n.op = mcu8_dec_pkg::OP_MOVE_IMMEDIATE;
				n.mode = mcu8_dec_pkg::AM_IMMEDIATE;
				n.imm = o2;
				n.eak = 1'b1;
				n.ea = o1;
				n.len = 2'h3;
			end
			8'hB2, 8'hB3: begin
				n.op = oc[0] ? mcu8_dec_pkg::OP_RETURN_SUBROUTINE : mcu8_dec_pkg::OP_RETURN_INTERRUPT;
				n.cyc = 3'h2;
				n.tkk = 1'b0;
				n.cc = 2'h2;
			end
			8'hB4, 8'hB5: begin
				n.op = oc[0] ? mcu8_dec_pkg::OP_ROTATE_ACC_LEFT : mcu8_dec_pkg::OP_COMPLEMENT_ACC;
				n.cc = 2'h2;
			end
			8'b1100????: begin
				n.op = oc[3] ? mcu8_dec_pkg::OP_TEST_SET_BRANCH : mcu8_dec_pkg::OP_TEST_CLEAR_BRANCH;
				n.len = 2'h3;
				n.cyc = 3'h5;
				n.rmw = 1'b1;
				n.eak = 1'b1;
				n.ea = o1;
				n.cc = 2'h1;
				n.cv = md[oc[2:0]];
				n.tk = ~(n.cv ^ oc[3]);
				n.brk = 1'b1;
				n.npc = p + 12'h3 + (n.tk ? {{4{o2[7]}}, o2} : 12'h0);
				n.mode = mcu8_dec_pkg::AM_BIT_TEST_BRANCH;
			end
			8'b1101????: begin
				n.op = oc[3] ? mcu8_dec_pkg::OP_SET_BIT : mcu8_dec_pkg::OP_CLEAR_BIT;
				n.mode = mcu8_dec_pkg::AM_BIT_SET_CLEAR;
				n.len = 2'h2;
				n.rmw = 1'b1;
				n.eak = 1'b1;
				n.ea = o1;
			end
			8'hE9, 8'hEE, 8'hEF: begin
				n.res = 1'b1;
				n.cyc = 3'h2;
			end
			8'b111?????: begin
				n.op = alu[oc[2:0]];
				n.len = oc[3] ? 2'h2 : 2'h1;
				n.rmw = &oc[2:1];
				n.eak = ~oc[3] | oc[4];
				n.ea = oc[3] ? o1 : (oc[4] ? y : x);
				n.cc = (oc[2:0] inside {3'h2, 3'h3, 3'h4}) ? 2'h2 : 2'h0;
				if (oc[4:0] == 5'h1C) n.cc = 2'h1;
				n.cv = cr < md;
				n.mode = oc[3] ? (oc[4] ? mcu8_dec_pkg::AM_DIRECT : mcu8_dec_pkg::AM_IMMEDIATE)
					: mcu8_dec_pkg::AM_REG_INDIRECT;
				n.imm = (oc[3] & ~oc[4]) ? o1 : 8'h00;
			end
			default: begin
				n.res = 1'b1;
				n.cyc = 3'h2;
			end
		endcase
		if (!v) begin
			n.op = mcu8_dec_pkg::OP_NONE;
			n.rmw = 1'b0;
			n.tk = 1'b0;
			n.tkk = 1'b1;
			n.brk = 1'b0;
			n.eak = 1'b0;
			n.cc = 2'h0;
		end
		return n;
	endfunction
	// ==========================================
	// Drivers
	task automatic issue(input logic v, input logic [7:0] oc, input logic [1:0] fl);
		mcu8_note_t n;
		@(posedge ref_clk);
		#1;
		op_valid = v;
		opcode = oc;
		operand1 = 8'($random(seed));
		operand2 = 8'($random(seed));
		pc = 12'($random(seed));
		flag_zero = fl[0];
		flag_carry = fl[1];
		fm.ram[8'h80] = 8'($random(seed));
		fm.ram[8'h81] = 8'($random(seed));
		n = predict(v, oc, operand1, operand2, pc, fl[0], fl[1], fm.ram[8'h80], fm.ram[8'h81],
			fm.ram[operand1], fm.ram[8'hFF]);
		n.stamp = cyc;
		notes.push_back(n);
	endtask
	task automatic drain;
		while (notes.size() > 0) @(posedge ref_clk);
	endtask
	task automatic do_reset;
		@(posedge ref_clk);
		#1;
		srst = 1'b1;
		repeat (2) @(posedge ref_clk);
		#1;
		cmp_op(mcu8_dec_pkg::OP_NONE, dec_op);
		cmp_val("dec_length", 12'h1, 12'(dec_length));
		cmp_val("dec_cycles", 12'h2, 12'(dec_cycles));
		cmp_val("dec_valid", 12'h0, 12'(dec_valid));
		srst = 1'b0;
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// ==========================================
	// Tests
	initial begin
		{srst, op_valid, opcode, operand1, operand2, pc, flag_zero, flag_carry} = '0;
		srst = 1'b1;
		do_reset();
		for (int i = 0; i < 512; i++) issue(1'b1, 8'(i), 2'($random(seed)));
		drain();
		$display("test opcode sweep done");
		issue(1'b1, 8'h20, 2'h1);
		issue(1'b1, 8'h30, 2'h1);
		issue(1'b1, 8'h4F, 2'h1);
		issue(1'b1, 8'h70, 2'h2);
		drain();
		$display("test branch edges done");
		for (int i = 0; i < 400; i++) issue(|2'($random(seed)), 8'($random(seed)), 2'($random(seed)));
		drain();
		$display("test random stream done");
		issue(1'b1, 8'hFE, 2'h0);
		drain();
		do_reset();
		issue(1'b1, 8'hCF, 2'h3);
		drain();
		$display("test mid-run reset done");
		complete_run();
	end
	initial begin
		#20000;
		mismatches++;
		$display("watchdog expired");
		complete_run();
	end
endmodule
`default_nettype wire
